// ---- core/pcpl_pkg.sv ----
// Purpose: Constants for the eight-pin parallel port logic
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Printed offsets are odd, so they are register indices
package pcpl_pkg;
    localparam int unsigned PCPL_WIDTH         = 8;
    localparam int unsigned PCPL_ADDR_W        = 12;
    // Register indices as printed; byte address is the low 12 bits of four times the index
    localparam logic [15:0] PCPL_IDX_DIR       = 16'hFE95;
    localparam logic [15:0] PCPL_IDX_DATA      = 16'hFE97;
    localparam logic [15:0] PCPL_IDX_PULLUP    = 16'hFE99;
    localparam logic [15:0] PCPL_IDX_MODE      = 16'hFE9B;
    localparam logic [11:0] PCPL_OFF_DIR       = 12'(PCPL_IDX_DIR * 4);
    localparam logic [11:0] PCPL_OFF_DATA      = 12'(PCPL_IDX_DATA * 4);
    localparam logic [11:0] PCPL_OFF_PULLUP    = 12'(PCPL_IDX_PULLUP * 4);
    localparam logic [11:0] PCPL_OFF_MODE      = 12'(PCPL_IDX_MODE * 4);
    localparam logic [7:0]  PCPL_DIR_RST       = 8'h00;
    localparam logic [7:0]  PCPL_DATA_RST      = 8'h00;
    localparam logic [7:0]  PCPL_PULLUP_RST    = 8'h00;
    localparam logic [7:0]  PCPL_DIR_READ      = 8'hFF;
    localparam logic [2:0]  PCPL_MODE_RST      = 3'h7;
    localparam int unsigned PCPL_MODE_LSB      = 0;
    localparam int unsigned PCPL_MODE_MSB      = 2;
    localparam int unsigned PCPL_SYNC_STAGES   = 2;
    typedef enum logic [1:0] {
        PCPL_FN_ADDR,
        PCPL_FN_SPLIT,
        PCPL_FN_GPIO
    } pcpl_fn_t;
endpackage

// ---- core/pcpl_sync.sv ----
// Purpose: Two-stage level synchroniser for the port pins
// Assumes: Inputs are asynchronous to core_clk
// Notes:   First stage feeds only the second
`timescale 1ns/100ps
module pcpl_sync
    import pcpl_pkg::*;
#(
    parameter int unsigned WIDTH = PCPL_WIDTH
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ---- core/pcpl_port.sv ----
// Purpose: Eight-pin port with address, input and output functions
// Assumes: APB slave, mode from a register, standby from the system
// Notes:   Software standby keeps all register contents
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module pcpl_port
    import pcpl_pkg::*;
#(
    parameter int unsigned WIDTH = PCPL_WIDTH
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             hw_standby,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [WIDTH-1:0] low_address_byte,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe,
    output logic      [WIDTH-1:0] pin_pullup_on_bit
);
    logic [WIDTH-1:0] port_direction_reg;
    logic [WIDTH-1:0] port_data_reg;
    logic [WIDTH-1:0] port_pullup_ctrl_reg;
    logic [2:0]       mode;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] data_view;
    logic [WIDTH-1:0] next_pin_out;
    logic [WIDTH-1:0] next_pin_oe;
    logic [WIDTH-1:0] next_pullup;
    logic [31:0]      next_prdata;
    logic             wr_en;
    logic             rd_en;
    logic             hit;
    pcpl_fn_t         fn;

    pcpl_sync #(.WIDTH(WIDTH)) u_sync
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    always_comb
    begin
        unique case (mode)
            3'h2, 3'h4: fn = PCPL_FN_SPLIT;
            3'h7:       fn = PCPL_FN_GPIO;
            default:    fn = PCPL_FN_ADDR;
        endcase
    end

    assign hit = (paddr == PCPL_OFF_DIR) || (paddr == PCPL_OFF_DATA)
              || (paddr == PCPL_OFF_PULLUP) || (paddr == PCPL_OFF_MODE);
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    // Zero wait states; reads prepared in setup so data is a flop
    assign pready  = 1'h1;
    assign pslverr = psel && penable && !hit;

    // Hardware standby clears direction, data and pull-up like reset, but not mode; software standby does not
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_direction_reg   <= PCPL_DIR_RST;
            port_data_reg        <= PCPL_DATA_RST;
            port_pullup_ctrl_reg <= PCPL_PULLUP_RST;
        end
        else if (hw_standby)
        begin
            port_direction_reg   <= PCPL_DIR_RST;
            port_data_reg        <= PCPL_DATA_RST;
            port_pullup_ctrl_reg <= PCPL_PULLUP_RST;
        end
        else if (wr_en)
        begin
            if (paddr == PCPL_OFF_DIR)
                port_direction_reg <= pwdata[WIDTH-1:0];
            if (paddr == PCPL_OFF_DATA)
                port_data_reg <= pwdata[WIDTH-1:0];
            if (paddr == PCPL_OFF_PULLUP)
                port_pullup_ctrl_reg <= pwdata[WIDTH-1:0];
        end
    end

    // Mode survives hardware standby; only reset restores it
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode <= PCPL_MODE_RST;
        else if (wr_en && paddr == PCPL_OFF_MODE)
            mode <= pwdata[PCPL_MODE_MSB:PCPL_MODE_LSB];
    end

    // Per-bit data read view
    always_comb
    begin
        data_view = port_data_reg;
        for (int i = 0; i < WIDTH; i++)
        begin
            unique case (fn)
                PCPL_FN_SPLIT:
                    if (!port_direction_reg[i])
                        data_view[i] = pin_sync[i];
                PCPL_FN_GPIO:
                    if (!port_direction_reg[i])
                        data_view[i] = port_pullup_ctrl_reg[i] | pin_sync[i];
                    else
                        data_view[i] = port_data_reg[i];
                PCPL_FN_ADDR:
                    data_view[i] = port_data_reg[i];
            endcase
        end
    end

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (paddr == PCPL_OFF_DIR)
            next_prdata[WIDTH-1:0] = PCPL_DIR_READ;
        else if (paddr == PCPL_OFF_DATA)
            next_prdata[WIDTH-1:0] = data_view;
        else if (paddr == PCPL_OFF_PULLUP)
            next_prdata[WIDTH-1:0] = port_pullup_ctrl_reg;
        else if (paddr == PCPL_OFF_MODE)
            next_prdata[PCPL_MODE_MSB:PCPL_MODE_LSB] = mode;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (rd_en)
            prdata <= next_prdata;
    end

    // Pin drive and pull-up
    always_comb
    begin
        // Defaults keep the unused function code from inferring a latch
        next_pin_out = '0;
        next_pin_oe  = '0;
        unique case (fn)
            PCPL_FN_ADDR:
            begin
                next_pin_out = low_address_byte;
                next_pin_oe  = '1;
            end
            PCPL_FN_SPLIT:
            begin
                next_pin_out = low_address_byte & port_direction_reg;
                next_pin_oe  = port_direction_reg;
            end
            PCPL_FN_GPIO:
            begin
                next_pin_out = port_data_reg & port_direction_reg;
                next_pin_oe  = port_direction_reg;
            end
        endcase
        next_pullup = (fn == PCPL_FN_GPIO)
                    ? (port_pullup_ctrl_reg & ~port_direction_reg) : '0;
        if (hw_standby)
        begin
            next_pullup = '0;
            next_pin_oe = '0;
        end
    end

    // Registered pins: one cycle of lag behind registers and address
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out           <= '0;
            pin_oe            <= '0;
            pin_pullup_on_bit <= '0;
        end
        else
        begin
            pin_out           <= next_pin_out;
            pin_oe            <= next_pin_oe;
            pin_pullup_on_bit <= next_pullup;
        end
    end

    pullup_input_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pin_pullup_on_bit != '0 |-> $past(fn == PCPL_FN_GPIO)
        && (pin_pullup_on_bit & $past(port_direction_reg)) == '0)
        else $error("pull-up on output or outside mode 7");
    standby_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        hw_standby |=> pin_pullup_on_bit == '0)
        else $error("pull-up on during standby");
    pullup_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fn == PCPL_FN_GPIO && !hw_standby |=>
        pin_pullup_on_bit == $past(port_pullup_ctrl_reg & ~port_direction_reg))
        else $error("pull-up does not follow control");
    dir_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_en && paddr == PCPL_OFF_DIR |=> prdata[WIDTH-1:0] == PCPL_DIR_READ)
        else $error("direction read not all ones");
    addr_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fn == PCPL_FN_ADDR && !hw_standby |=>
        pin_oe == '1 && pin_out == $past(low_address_byte))
        else $error("address byte not driven");
    out_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fn == PCPL_FN_GPIO && !hw_standby |=>
        pin_oe == $past(port_direction_reg)
        && (pin_out & pin_oe) == $past(port_data_reg & port_direction_reg))
        else $error("output pin not driving stored data");
    pulled_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_en && paddr == PCPL_OFF_DATA && fn == PCPL_FN_GPIO |=>
        (prdata[WIDTH-1:0] & $past(port_pullup_ctrl_reg & ~port_direction_reg))
        == $past(port_pullup_ctrl_reg & ~port_direction_reg))
        else $error("pulled input did not read one");
    addr_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_en && paddr == PCPL_OFF_DATA && fn == PCPL_FN_ADDR |=>
        prdata[WIDTH-1:0] == $past(port_data_reg))
        else $error("address mode read not stored value");
    split_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_en && paddr == PCPL_OFF_DATA && fn == PCPL_FN_SPLIT |=>
        (prdata[WIDTH-1:0] & ~$past(port_direction_reg))
        == $past(pin_sync & ~port_direction_reg))
        else $error("input read not pin level");
    standby_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        hw_standby |=> pin_oe == '0)
        else $error("pin driven during standby");
    pullup_ignore_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fn != PCPL_FN_GPIO |=> pin_pullup_on_bit == '0)
        else $error("pull-up on outside mode 7");
    input_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fn != PCPL_FN_ADDR |=> (pin_oe & ~$past(port_direction_reg)) == '0)
        else $error("input pin driven");
    split_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fn == PCPL_FN_SPLIT && !hw_standby |=>
        pin_oe == $past(port_direction_reg)
        && (pin_out & pin_oe) == $past(low_address_byte & port_direction_reg))
        else $error("address not driven on output pins");

    // Data read in two steps: setup loads prdata, access shows it
    sequence data_setup_s;
        rd_en && paddr == PCPL_OFF_DATA;
    endsequence
    open_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        data_setup_s ##0 fn == PCPL_FN_GPIO |=>
        (prdata[WIDTH-1:0] & $past(~port_pullup_ctrl_reg & ~port_direction_reg))
        == $past(pin_sync & ~port_pullup_ctrl_reg & ~port_direction_reg))
        else $error("input without pull-up did not read pin");
    split_addr_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        data_setup_s ##0 fn == PCPL_FN_SPLIT |=>
        (prdata[WIDTH-1:0] & $past(port_direction_reg))
        == $past(port_data_reg & port_direction_reg))
        else $error("address pin read not stored value");
endmodule

// ---- tb/pcpl_pins.sv ----
// Purpose: Model of the circuitry on the eight port pins
// Assumes: Device drive wins over the external driver
// Notes:   Undriven pins without pull-up change every cycle
`timescale 1ns/100ps
module pcpl_pins
(
    input  wire logic       core_clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup_on_bit,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output logic      [7:0] pin_level
);
    logic [7:0] float_pat = 8'h55;

    // Floating pins must not look like a stable value
    always @(posedge core_clk)
        float_pat <= ~float_pat;

    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                     | (~pin_oe & ~ext_en & (pin_pullup_on_bit | float_pat));
endmodule

// ---- tb/port_c_pin_logic_bench.sv ----
// Purpose: Self-checking bench for the parallel port logic
// Assumes: Zero-wait APB slave, mode register beside the port ones
// Notes:   Pin checks wait out output and sync lags
`timescale 1ns/100ps
module port_c_pin_logic_bench
    import pcpl_pkg::*;
;
    logic        core_clk;
    logic        rst_n;
    logic        hw_standby;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  addr_byte;
    logic [7:0]  pin_level;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [7:0]  pin_pullup_on_bit;
    logic [7:0]  ext_val;
    logic [7:0]  ext_en;
    logic [31:0] rd;
    logic        rd_err;
    int          err_total = 0;
    int          compares = 0;
    int          cycles = 0;

    pcpl_port uut (.core_clk(core_clk), .rst_n(rst_n), .hw_standby(hw_standby),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_address_byte(addr_byte), .pin_in(pin_level), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup_on_bit(pin_pullup_on_bit));

    pcpl_pins model (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_on_bit(pin_pullup_on_bit), .ext_val(ext_val),
        .ext_en(ext_en), .pin_level(pin_level));

    initial
    begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("Mismatches %0d, compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Whole transfer held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'h1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do
            @(posedge core_clk);
        while (pready !== 1'h1);
        rd      = prdata;
        rd_err  = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    // Pins lag one cycle, pin reads two more
    task automatic settle();
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_total++;
            stop_test();
        end
    end

    initial
    begin
        rst_n = 1'h0;
        hw_standby = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        addr_byte = 8'h00;
        ext_val = 8'h5A;
        ext_en = 8'hFF;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        settle();
        chk("oe", pin_oe, 32'h0);
        apb(1'h1, PCPL_OFF_DIR, 32'h0F);
        apb(1'h0, PCPL_OFF_DIR, 32'h0);
        chk("dir rd", rd, 32'hFF);
        apb(1'h1, PCPL_OFF_DIR, 32'h00);
        // Released pins need the output lag plus two sync stages
        settle();
        apb(1'h0, PCPL_OFF_DATA, 32'h0);
        chk("in rd", rd, 32'h5A);
        apb(1'h1, PCPL_OFF_PULLUP, 32'hF0);
        ext_en <= 8'hF0;
        ext_val <= 8'h00;
        apb(1'h1, PCPL_OFF_DIR, 32'h0F);
        apb(1'h1, PCPL_OFF_DATA, 32'h3C);
        settle();
        chk("oe m7", pin_oe, 32'h0F);
        chk("out m7", pin_out & 8'h0F, 32'h0C);
        chk("pu m7", pin_pullup_on_bit, 32'hF0);
        apb(1'h0, PCPL_OFF_DATA, 32'h0);
        chk("data m7", rd, 32'hFC);
        apb(1'h1, PCPL_OFF_DIR, 32'hFF);
        settle();
        chk("pu out", pin_pullup_on_bit, 32'h0);
        apb(1'h1, PCPL_OFF_DIR, 32'h0F);
        ext_val <= 8'hA0;
        for (int m = 2; m <= 4; m += 2)
        begin
            apb(1'h1, PCPL_OFF_MODE, 32'(m));
            addr_byte <= 8'h90 | 8'(m);
            apb(1'h1, PCPL_OFF_DATA, 32'h55);
            settle();
            chk("oe m24", pin_oe, 32'h0F);
            chk("adr m24", pin_out & 8'h0F, 32'(m));
            chk("pu m24", pin_pullup_on_bit, 32'h0);
            apb(1'h0, PCPL_OFF_DATA, 32'h0);
            chk("data m24", rd, 32'hA5);
        end
        for (int m = 1; m <= 6; m++)
        begin
            if (m == 2 || m == 4)
                continue;
            apb(1'h1, PCPL_OFF_MODE, 32'(m));
            addr_byte <= 8'h3C ^ 8'(m);
            apb(1'h1, PCPL_OFF_DATA, 32'hE7);
            settle();
            chk("oe adr", pin_oe, 32'hFF);
            chk("adr", pin_out, 32'(8'h3C ^ 8'(m)));
            chk("pu adr", pin_pullup_on_bit, 32'h0);
            apb(1'h0, PCPL_OFF_DATA, 32'h0);
            chk("data adr", rd, 32'hE7);
        end
        apb(1'h0, 12'h000, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("slverr", 32'(rd_err), 32'h1);
        apb(1'h1, PCPL_OFF_MODE, 32'h7);
        apb(1'h1, PCPL_OFF_DIR, 32'h00);
        settle();
        chk("pu m7 on", pin_pullup_on_bit, 32'hF0);
        apb(1'h0, PCPL_OFF_MODE, 32'h0);
        hw_standby <= 1'h1;
        settle();
        chk("pu stby", pin_pullup_on_bit, 32'h0);
        apb(1'h0, PCPL_OFF_MODE, 32'h0);
        hw_standby <= 1'h0;
        apb(1'h0, PCPL_OFF_PULLUP, 32'h0);
        chk("pu clr", rd, 32'h0);
        apb(1'h1, PCPL_OFF_PULLUP, 32'h0F);
        settle();
        chk("pu again", pin_pullup_on_bit, 32'h0F);
        apb(1'h0, PCPL_OFF_PULLUP, 32'h0);
        rst_n <= 1'h0;
        @(negedge core_clk);
        chk("pu rst", pin_pullup_on_bit, 32'h0);
        @(posedge core_clk);
        rst_n <= 1'h1;
        settle();
        chk("pu after", pin_pullup_on_bit, 32'h0);
        stop_test();
    end
endmodule
